/* File: hw/rsim_consts.svh */
// constants for the receiver status and interrupt mask block
// assumes inclusion by bare name from the top module
`ifndef RSIM_CONSTS_SVH
`define RSIM_CONSTS_SVH

`define RSIM_ADDR_STAT2      8'h14
`define RSIM_ADDR_STAT3      8'h15
`define RSIM_ADDR_MASK1      8'h16
`define RSIM_ADDR_MASK2      8'h17

`define RSIM_MASK1_RESET     8'h00
`define RSIM_MASK2_RESET     1'h0
`define RSIM_STAT2_RESET     8'h00
`define RSIM_ZERO_BYTE       8'h00

`define RSIM_BIT_CSCRC       7
`define RSIM_BIT_PARITY      6
`define RSIM_BIT_VALIDITY    5
`define RSIM_BIT_BIPHASE     4
`define RSIM_BIT_SUBCHG      3
`define RSIM_BIT_UNLOCK      2
`define RSIM_BIT_SUBCRC      1
`define RSIM_BIT_RBT         0
`define RSIM_BIT_SLIP        0

`endif

/* File: hw/rsim_pkg.sv */
// types for the receiver status and interrupt mask block
// assumes the constants header sits beside it
package rsim_pkg;
  typedef struct packed {
    logic [7:0] stat2;
    logic       outputSlipError;
    logic [7:0] mask1;
    logic       outputSlipIrqEnable;
    logic [7:0] rdata;
    logic       irq;
  } rsim_state_t;

  typedef struct packed {
    logic slipEvt;
  } rsim_mon_t;
endpackage : rsim_pkg

/* File: hw/rsim_slip_if.sv */
// carrier between the top and the output slip monitor
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface rsim_slip_if;
  logic portASrcRx;
  logic portASlave;
  logic portBSrcRx;
  logic portBSlave;
  logic slipA;
  logic slipB;
  logic slipEvt;

  modport mon (input portASrcRx, portASlave, portBSrcRx, portBSlave, slipA, slipB,
               output slipEvt);
  modport top (output portASrcRx, portASlave, portBSrcRx, portBSlave, slipA, slipB,
               input slipEvt);
endinterface : rsim_slip_if

/* File: hw/rsim_slip_mon.sv */
// picks the audio serial port whose slips count as output slip errors
// assumes slip pulses come from the port logic, one cycle per slip
`timescale 1ns/10ps
module rsim_slip_mon
  import rsim_pkg::*;
(
  input wire logic  clk,
  input wire logic  resetn,
  rsim_slip_if.mon  sl
);
  rsim_mon_t st_q;
  rsim_mon_t st_d;

  always_comb begin
    st_d = st_q;
    // port a wins when both ports take the receiver output
    if (sl.portASrcRx) begin
      st_d.slipEvt = sl.portASlave && sl.slipA;
    end else if (sl.portBSrcRx) begin
      st_d.slipEvt = sl.portBSlave && sl.slipB;
    end else begin
      st_d.slipEvt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sl.slipEvt = st_q.slipEvt;
endmodule : rsim_slip_mon

/* File: hw/rsim_top.sv */
// receiver status and interrupt mask registers with output slip monitor
// assumes a serial control port front end presents byte-wide register
// accesses as single-cycle read and write strobes
//
// Contract
// - buffer transfer done sets status bit to one
// - status 3 read-only, bits 7..1 zero
// - slip or repeat sets slip bit, else zero
// - slip interrupt only when second mask enables
// - slip errors only for slave port sourcing receiver
// - single receiver-sourced port is the monitored one
// - both ports sourced: monitor port a only
// - bit 7 masks checksum interrupt, default masked
// - bit 6 masks parity interrupt, default masked
// - bit 5 masks validity interrupt, default masked
// - status 2 interrupts gated by first mask
`timescale 1ns/10ps
`include "rsim_consts.svh"
module rsim_top
  import rsim_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            irqOut,
  input  wire logic [7:0] rxEvents,
  input  wire logic       portASrcRx,
  input  wire logic       portASlave,
  input  wire logic       portBSrcRx,
  input  wire logic       portBSlave,
  input  wire logic       slipA,
  input  wire logic       slipB
);
  rsim_state_t st_q;
  rsim_state_t st_d;
  rsim_slip_if sl ();

  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] target);
    addrHit = (a == target);
  endfunction : addrHit

  assign sl.portASrcRx = portASrcRx;
  assign sl.portASlave = portASlave;
  assign sl.portBSrcRx = portBSrcRx;
  assign sl.portBSlave = portBSlave;
  assign sl.slipA      = slipA;
  assign sl.slipB      = slipB;

  rsim_slip_mon u_mon (
    .clk    (clk),
    .resetn (resetn),
    .sl     (sl)
  );

  always_comb begin
    logic rdStat2;
    logic rdStat3;
    rdStat2 = regRd && addrHit(regAddr, `RSIM_ADDR_STAT2);
    rdStat3 = regRd && addrHit(regAddr, `RSIM_ADDR_STAT3);
    st_d = st_q;
    // read data is taken before the read clears anything
    if (regRd) begin
      unique case (1'b1)
        addrHit(regAddr, `RSIM_ADDR_STAT2): st_d.rdata = st_q.stat2;
        addrHit(regAddr, `RSIM_ADDR_STAT3): st_d.rdata = {7'h00, st_q.outputSlipError};
        addrHit(regAddr, `RSIM_ADDR_MASK1): st_d.rdata = st_q.mask1;
        addrHit(regAddr, `RSIM_ADDR_MASK2): st_d.rdata = {7'h00, st_q.outputSlipIrqEnable};
        default:                            st_d.rdata = `RSIM_ZERO_BYTE;
      endcase
    end
    // events are sticky until read; a set in the clearing cycle survives
    st_d.stat2 = (rdStat2 ? `RSIM_ZERO_BYTE : st_q.stat2) | rxEvents;
    st_d.outputSlipError = (!rdStat3 && st_q.outputSlipError) || sl.slipEvt;
    if (regWr && addrHit(regAddr, `RSIM_ADDR_MASK1)) begin
      st_d.mask1 = regWdata;
    end
    if (regWr && addrHit(regAddr, `RSIM_ADDR_MASK2)) begin
      st_d.outputSlipIrqEnable = regWdata[`RSIM_BIT_SLIP];
    end
    st_d.irq = (|(st_d.stat2 & st_d.mask1))
               || (st_d.outputSlipError && st_d.outputSlipIrqEnable);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.stat2               <= `RSIM_STAT2_RESET;
      st_q.outputSlipError     <= 1'b0;
      st_q.mask1               <= `RSIM_MASK1_RESET;
      st_q.outputSlipIrqEnable <= `RSIM_MASK2_RESET;
      st_q.rdata               <= `RSIM_ZERO_BYTE;
      st_q.irq                 <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign regRdata = st_q.rdata;
  assign irqOut   = st_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rbt_sets: assert property (rxEvents[`RSIM_BIT_RBT] |=> st_q.stat2[`RSIM_BIT_RBT])
    else $error("buffer transfer done not reported");
  a_stat3_upper: assert property ((regRd && regAddr == `RSIM_ADDR_STAT3)
      |=> regRdata[7:1] == 7'h00)
    else $error("status 3 upper bits not zero");
  a_slip_sets: assert property (sl.slipEvt |=> st_q.outputSlipError)
    else $error("slip event not recorded");
  a_slip_clears: assert property ((regRd && regAddr == `RSIM_ADDR_STAT3 && !sl.slipEvt)
      |=> !st_q.outputSlipError)
    else $error("slip status not cleared by read");
  a_slip_gate: assert property ((st_q.outputSlipError && !st_q.outputSlipIrqEnable
      && ((st_q.stat2 & st_q.mask1) == 8'h00)) |-> !irqOut)
    else $error("slip interrupt while masked");
  a_slave_only: assert property (!((portASrcRx && portASlave && slipA)
      || (!portASrcRx && portBSrcRx && portBSlave && slipB)) |=> !sl.slipEvt)
    else $error("slip event without slave receiver port");
  a_single_b: assert property ((!portASrcRx && portBSrcRx && portBSlave && slipB)
      |=> sl.slipEvt)
    else $error("port b slip missed");
  a_both_porta: assert property ((portASrcRx && portBSrcRx && slipB && !slipA)
      |=> !sl.slipEvt)
    else $error("port b slip counted while port a monitored");
  a_mask_write: assert property ((regWr && regAddr == `RSIM_ADDR_MASK1)
      |=> st_q.mask1 == $past(regWdata))
    else $error("mask register not written");
  a_status_irq: assert property (((st_q.stat2 & st_q.mask1) != 8'h00) |-> irqOut)
    else $error("enabled status did not interrupt");

  // register side: reads show the stored value, writes land only where mapped
  a_stat2_read: assert property (
      (regRd && regAddr == `RSIM_ADDR_STAT2)
      |=> regRdata == $past(st_q.stat2))
    else $error("status 2 read data wrong");
  a_stat2_sticky: assert property (
      !(regRd && regAddr == `RSIM_ADDR_STAT2)
      |=> (st_q.stat2 & $past(st_q.stat2)) == $past(st_q.stat2))
    else $error("status 2 bit lost without a read");
  a_stat3_ro: assert property (
      (regWr && !regRd && regAddr == `RSIM_ADDR_STAT3 && !sl.slipEvt)
      |=> st_q.outputSlipError == $past(st_q.outputSlipError))
    else $error("status 3 changed by a write");
  a_stat3_value: assert property (
      (regRd && regAddr == `RSIM_ADDR_STAT3)
      |=> regRdata[0] == $past(st_q.outputSlipError))
    else $error("status 3 read data wrong");
  a_slip_hold: assert property (
      (!sl.slipEvt && !(regRd && regAddr == `RSIM_ADDR_STAT3))
      |=> st_q.outputSlipError == $past(st_q.outputSlipError))
    else $error("slip status changed without cause");
  a_mask_read: assert property (
      (regRd && regAddr == `RSIM_ADDR_MASK1)
      |=> regRdata == $past(st_q.mask1))
    else $error("mask 1 read data wrong");
  a_mask_hold: assert property (
      !(regWr && regAddr == `RSIM_ADDR_MASK1)
      |=> st_q.mask1 == $past(st_q.mask1))
    else $error("mask 1 changed without a write");
  a_mask2_write: assert property (
      (regWr && regAddr == `RSIM_ADDR_MASK2)
      |=> {7'h00, st_q.outputSlipIrqEnable} == ($past(regWdata) & 8'h01))
    else $error("slip enable not written");
  a_mask2_hold: assert property (
      !(regWr && regAddr == `RSIM_ADDR_MASK2)
      |=> st_q.outputSlipIrqEnable == $past(st_q.outputSlipIrqEnable))
    else $error("slip enable changed without a write");

  // port choice: only a slave port that takes the receiver output counts
  a_no_source: assert property (
      (!portASrcRx && !portBSrcRx)
      |=> !sl.slipEvt)
    else $error("slip event with no receiver-sourced port");
  a_master_a: assert property (
      (portASrcRx && !portASlave)
      |=> !sl.slipEvt)
    else $error("slip event from master port a");
  a_master_b: assert property (
      (!portASrcRx && !portBSlave)
      |=> !sl.slipEvt)
    else $error("slip event from master port b");
  a_single_a: assert property (
      (portASrcRx && !portBSrcRx && portASlave && slipA)
      |=> sl.slipEvt)
    else $error("port a slip missed");
  a_both_a: assert property (
      (portASrcRx && portBSrcRx && portASlave && slipA)
      |=> sl.slipEvt)
    else $error("port a slip missed with both ports sourced");

  // the interrupt follows each enabled status bit in the same cycle
  a_slip_irq: assert property (
      (st_q.outputSlipError && st_q.outputSlipIrqEnable)
      |-> irqOut)
    else $error("enabled slip did not interrupt");
  a_chstat_irq: assert property (
      (st_q.stat2[`RSIM_BIT_CSCRC] && st_q.mask1[`RSIM_BIT_CSCRC])
      |-> irqOut)
    else $error("enabled checksum error did not interrupt");
  a_parity_irq: assert property (
      (st_q.stat2[`RSIM_BIT_PARITY] && st_q.mask1[`RSIM_BIT_PARITY])
      |-> irqOut)
    else $error("enabled parity error did not interrupt");
  a_validity_irq: assert property (
      (st_q.stat2[`RSIM_BIT_VALIDITY] && st_q.mask1[`RSIM_BIT_VALIDITY])
      |-> irqOut)
    else $error("enabled validity flag did not interrupt");
  a_low_irq: assert property (
      ((st_q.stat2[4:0] & st_q.mask1[4:0]) != 5'h00)
      |-> irqOut)
    else $error("enabled low status bit did not interrupt");
  a_irq_quiet: assert property (
      (((st_q.stat2 & st_q.mask1) == 8'h00) && !(st_q.outputSlipError && st_q.outputSlipIrqEnable))
      |-> !irqOut)
    else $error("interrupt with every source masked");

  c_rbt_irq: cover property (rxEvents[`RSIM_BIT_RBT] && st_q.mask1[`RSIM_BIT_RBT] ##1 irqOut);
  c_slip_irq: cover property (sl.slipEvt && st_q.outputSlipIrqEnable ##1 irqOut);
  c_read_clear: cover property (st_q.outputSlipError && regRd && regAddr == `RSIM_ADDR_STAT3);
  c_both_ports: cover property (portASrcRx && portBSrcRx && portASlave && slipA ##1 sl.slipEvt);
  c_mask2_write: cover property (regWr && regAddr == `RSIM_ADDR_MASK2 ##1 st_q.outputSlipIrqEnable);
endmodule : rsim_top

/* File: testbench/rsim_host.sv */
// host model issuing single-byte register accesses
// assumes accesses are taken at the rising clock edge
`timescale 1ns/10ps
module rsim_host (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic            regWr,
  output logic            regRd,
  output logic      [7:0] regWdata,
  output logic            rdDone
);
  initial begin
    regAddr  = 8'h00;
    regWr    = 1'b0;
    regRd    = 1'b0;
    regWdata = 8'h00;
  end
  // data is valid one edge after the strobe is taken
  always @(posedge clk) rdDone <= regRd;
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd   <= 1'b0;
  endtask : rd
endmodule : rsim_host

/* File: testbench/tb.sv */
// self-checking bench for the receiver status and mask block
// assumes the host model drives the register strobes
`timescale 1ns/10ps
module tb;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] regAddr, regWdata, regRdata, v;
  logic [7:0] rxEvents = 8'h00;
  logic       regWr, regRd, irqOut, rdDone;
  logic       aSrc = 0, aSl = 0, bSrc = 0, bSl = 0, slA = 0, slB = 0;
  logic [7:0] expQ[$];
  int         mismatches = 0;
  int         samples_checked = 0;
  // {aSrc, aSl, bSrc, bSl, slipA, slipB, expected}
  logic [6:0] slipCase[8] = '{7'b1100101, 7'b1100010, 7'b1000100, 7'b0011011,
                              7'b0011100, 7'b1111010, 7'b1111101, 7'b0101100};
  always #25 clk = ~clk;
  rsim_top dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .irqOut(irqOut),
    .rxEvents(rxEvents), .portASrcRx(aSrc), .portASlave(aSl), .portBSrcRx(bSrc),
    .portBSlave(bSl), .slipA(slA), .slipB(slB));
  rsim_host host (.clk(clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWdata(regWdata), .rdDone(rdDone));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic rd(logic [7:0] a, logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask : rd
  // sticky status lets the wait be generous
  task automatic irq(logic e);
    repeat (3) @(posedge clk);
    #1 check("irqOut", {7'h00, irqOut}, {7'h00, e});
  endtask : irq
  always @(posedge clk) if (rdDone === 1'b1) check("regRdata", regRdata, expQ.pop_front());
  initial begin
    #250000;
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(3354));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 8'h14; a <= 8'h18; a++) rd(a[7:0], 8'h00);
    v = 8'($urandom());
    host.wr(8'h16, v);
    host.wr(8'h15, 8'hff);
    host.wr(8'h17, 8'hff);
    rd(8'h16, v);
    rd(8'h15, 8'h00);
    rd(8'h17, 8'h01);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        host.wr(8'h16, m ? ~(8'h01 << i) : (8'h01 << i));
        rxEvents <= 8'h01 << i;
        @(posedge clk);
        rxEvents <= 8'h00;
        irq(m == 0);
        rd(8'h14, 8'h01 << i);
        irq(1'b0);
      end
    end
    $display("test events done");
    host.wr(8'h16, 8'h00);
    foreach (slipCase[k]) begin
      host.wr(8'h17, {7'h00, k[0] | k[1]});
      {aSrc, aSl, bSrc, bSl} <= slipCase[k][6:3];
      @(posedge clk);
      {slA, slB} <= slipCase[k][2:1];
      @(posedge clk);
      {slA, slB} <= 2'b00;
      irq(slipCase[k][0] & (k[0] | k[1]));
      rd(8'h15, {7'h00, slipCase[k][0]});
      irq(1'b0);
    end
    $display("test slips done");
    give_verdict();
  end
endmodule : tb
